/* stp_pkg.sv */
// constants and types shared by the speech test port design
// assumes a 100 MHz system clock; no timescale in packages
package stp_pkg;

   // -------------------------------------------------------
   // clocking and word format
   // -------------------------------------------------------
   localparam int CLK_HZ      = 100_000_000;
   localparam int BIT_HZ      = 104_000;
   localparam int SAMPLE_HZ   = 8_000;
   localparam int WORD_BITS   = 13;
   localparam int HALF_W      = 10;
   // half period of the link clock, rounded down to whole cycles
   localparam int HALF_CYC    = CLK_HZ / (2 * BIT_HZ);
   localparam int SYNC_STAGES = 2;

   // -------------------------------------------------------
   // reset values and levels
   // -------------------------------------------------------
   localparam logic SCLK_IDLE    = 1'b1;
   localparam logic SDO_IDLE     = 1'b1;
   localparam logic PIN_RST_ON   = 1'b0;

   typedef logic [WORD_BITS-1:0] stp_sample_t;
   typedef logic [HALF_W-1:0]    stp_half_t;

   // mode encoding is {control line 1, control line 2}
   typedef enum logic [1:0]
   {
      MODE_NORMAL   = 2'b00,
      MODE_DOWNLINK = 2'b01,
      MODE_UPLINK   = 2'b10,
      MODE_ACOUSTIC = 2'b11
   } stp_mode_e;

   localparam stp_sample_t SAMPLE_ZERO = 13'h0000;

endpackage

/* stp_word_if.sv */
// word-level handshake between the port controller and the bit engine
// assumes both ends run on sys_clk
`timescale 1ns/1ps
`default_nettype none
interface stp_word_if;
   import stp_pkg::*;
   logic        start;
   stp_sample_t tx_word;
   stp_sample_t rx_word;
   logic        done;
   logic        busy;

   modport ctrl
   (
      output start,
      output tx_word,
      input  rx_word,
      input  done,
      input  busy
   );

   modport engine
   (
      input  start,
      input  tx_word,
      output rx_word,
      output done,
      output busy
   );
endinterface
`default_nettype wire

/* stp_bit_engine.sv */
// bit engine: makes the link clock and shifts one 13-bit word each way
// assumes the data input is already synchronised to sys_clk
`timescale 1ns/1ps
`default_nettype none
module stp_bit_engine
(
   // system
   input  wire logic      sys_clk,
   input  wire logic      sys_rst,
   // word side
   stp_word_if.engine     wd,
   // link pins
   input  wire logic      sdi_sync,
   output logic           sclk,
   output logic           sdata_out
);
   import stp_pkg::*;

   typedef enum logic [1:0]
   {
      SD_IDLE = 2'b00,
      SD_LOW  = 2'b01,
      SD_HIGH = 2'b10
   } stp_sd_e;

   stp_sd_e     st_reg, st_next;
   stp_half_t   cnt_reg, cnt_next;
   logic [3:0]  bit_reg, bit_next;
   stp_sample_t tx_reg, tx_next;
   stp_sample_t rx_reg, rx_next;
   logic        sclk_reg, sclk_next;
   logic        sdo_reg, sdo_next;
   logic        done_reg, done_next;

   function automatic stp_sample_t shl1(input stp_sample_t w);
      shl1 = {w[WORD_BITS-2:0], 1'b0};
   endfunction

   // -------------------------------------------------------
   // next state
   // -------------------------------------------------------
   always_comb
   begin
      st_next   = st_reg;
      cnt_next  = cnt_reg;
      bit_next  = bit_reg;
      tx_next   = tx_reg;
      rx_next   = rx_reg;
      sclk_next = sclk_reg;
      sdo_next  = sdo_reg;
      done_next = 1'b0;
      case (st_reg)
         SD_IDLE:
         begin
            sclk_next = SCLK_IDLE;
            if (wd.start)
            begin
               sclk_next = 1'b0;
               sdo_next  = wd.tx_word[WORD_BITS-1];
               tx_next   = shl1(wd.tx_word);
               bit_next  = 4'h0;
               cnt_next  = '0;
               st_next   = SD_LOW;
            end
         end
         SD_LOW:
         begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == stp_half_t'(HALF_CYC - 1))
            begin
               cnt_next  = '0;
               sclk_next = 1'b1;
               rx_next   = {rx_reg[WORD_BITS-2:0], sdi_sync};
               st_next   = SD_HIGH;
            end
         end
         SD_HIGH:
         begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == stp_half_t'(HALF_CYC - 1))
            begin
               cnt_next = '0;
               if (bit_reg == 4'(WORD_BITS - 1))
               begin
                  done_next = 1'b1;
                  st_next   = SD_IDLE;
               end
               else
               begin
                  bit_next  = bit_reg + 1'b1;
                  sclk_next = 1'b0;
                  sdo_next  = tx_reg[WORD_BITS-1];
                  tx_next   = shl1(tx_reg);
                  st_next   = SD_LOW;
               end
            end
         end
         default:
         begin
            st_next   = SD_IDLE;
            sclk_next = SCLK_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         st_reg   <= SD_IDLE;
         cnt_reg  <= '0;
         bit_reg  <= 4'h0;
         tx_reg   <= SAMPLE_ZERO;
         rx_reg   <= SAMPLE_ZERO;
         sclk_reg <= SCLK_IDLE;
         sdo_reg  <= SDO_IDLE;
         done_reg <= 1'b0;
      end
      else
      begin
         st_reg   <= st_next;
         cnt_reg  <= cnt_next;
         bit_reg  <= bit_next;
         tx_reg   <= tx_next;
         rx_reg   <= rx_next;
         sclk_reg <= sclk_next;
         sdo_reg  <= sdo_next;
         done_reg <= done_next;
      end
   end

   assign sclk       = sclk_reg;
   assign sdata_out  = sdo_reg;
   assign wd.rx_word = rx_reg;
   assign wd.done    = done_reg;
   assign wd.busy    = (st_reg != SD_IDLE);

   // -------------------------------------------------------
   // checks
   // -------------------------------------------------------
   idle_clk_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (st_reg == SD_IDLE) |-> sclk_reg)
      else $error("link clock low while idle");
   sdo_on_fall_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !$stable(sdo_reg) |-> $fell(sclk_reg))
      else $error("data out changed away from a falling edge");
   rx_on_rise_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !$stable(rx_reg) |-> $rose(sclk_reg))
      else $error("data in captured away from a rising edge");
endmodule
`default_nettype wire

/* stp_port.sv */
// speech test port of the handset: mode control, transcoder reset and
// on-demand serial sample exchange with the external test simulator.
// assumes control pins and data input are asynchronous to sys_clk;
// codec side signals are synchronous to sys_clk.
//
// Notes on behaviour
// - reset pin is active low; high means released
// - each sample is 13-bit two's complement, most significant bit first
// - receiving side captures its data line on the rising link clock edge
// - transmitting side changes its data line on the falling edge
// - handset holds link clock high when no transfer runs
// - mode lines pick normal, downlink, uplink or acoustic test
// - mode may instead come from a configuration message
// - after reset release, clock pulses only when data needed or ready
// - uplink: first fall requests first bit, after next block boundary
// - downlink: first fall gives first bit of first frames completed
// - reset release in any test mode resets the speech transcoders
// - 8000 samples per second each way at 104 kbit/s
// - handset alone drives the link clock
// - asserted reset pin resets transcoder and converters; here only conv_rst follows the pin, transcoder_rst pulses at release in a test mode
`timescale 1ns/1ps
`default_nettype none
module stp_port
(
   // system
   input  wire logic               sys_clk,
   input  wire logic               sys_rst,
   // pins from the simulator
   input  wire logic               tst_ctrl1,
   input  wire logic               tst_ctrl2,
   input  wire logic               tst_rst_n,
   input  wire logic               tst_sdata_in,
   // pins to the simulator
   output logic                    tst_sclk,
   output logic                    tst_sdata_out,
   // configuration message path
   input  wire logic               cfg_use_msg,
   input  wire logic               cfg_msg_valid,
   input  wire stp_pkg::stp_mode_e cfg_msg_mode,
   // frame timing from the radio side
   input  wire logic               ul_block_start,
   input  wire logic               dl_frames_done,
   // samples towards the encoder or d/a
   output stp_pkg::stp_sample_t    ul_sample,
   output logic                    ul_valid,
   input  wire logic               ul_ready,
   // samples from the decoder or a/d
   input  wire stp_pkg::stp_sample_t dl_sample,
   input  wire logic               dl_valid,
   output logic                    dl_ready,
   // control outputs
   output stp_pkg::stp_mode_e      path_mode,
   output logic                    transcoder_rst,
   output logic                    conv_rst,
   output logic                    test_active
);
   import stp_pkg::*;

   // -------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------
   logic [3:0] sync1_reg, sync2_reg;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         // idle pin levels, so sys_rst is not followed by a false release
         sync1_reg <= {2'b00, ~PIN_RST_ON, 1'b1};
         sync2_reg <= {2'b00, ~PIN_RST_ON, 1'b1};
      end
      else
      begin
         sync1_reg <= {tst_ctrl1, tst_ctrl2, tst_rst_n, tst_sdata_in};
         sync2_reg <= sync1_reg;
      end
   end

   logic m1_s, m2_s, rst_n_s, sdi_s;
   assign {m1_s, m2_s, rst_n_s, sdi_s} = sync2_reg;

   // -------------------------------------------------------
   // mode selection
   // -------------------------------------------------------
   stp_mode_e msg_mode_reg, msg_mode_next;
   stp_mode_e mode_reg, mode_next;
   logic      rst_act;
   logic      rst_prev_reg, rst_prev_next;
   logic      release_ev;

   assign rst_act    = (rst_n_s == PIN_RST_ON);
   assign release_ev = rst_prev_reg && !rst_act;

   always_comb
   begin
      msg_mode_next = msg_mode_reg;
      if (cfg_msg_valid)
         msg_mode_next = cfg_msg_mode;
      // message path replaces the lines when selected
      if (cfg_use_msg)
         mode_next = msg_mode_reg;
      else
         mode_next = stp_mode_e'({m1_s, m2_s});
      rst_prev_next = rst_act;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         msg_mode_reg <= MODE_NORMAL;
         mode_reg     <= MODE_NORMAL;
         rst_prev_reg <= 1'b0;
      end
      else
      begin
         msg_mode_reg <= msg_mode_next;
         mode_reg     <= mode_next;
         rst_prev_reg <= rst_prev_next;
      end
   end

   // -------------------------------------------------------
   // test sequencer
   // -------------------------------------------------------
   typedef enum logic [2:0]
   {
      T_IDLE  = 3'b000,
      T_HOLD  = 3'b001,
      T_WAIT  = 3'b010,
      T_READY = 3'b011,
      T_XFER  = 3'b100
   } stp_seq_e;

   stp_word_if wd ();

   stp_seq_e    st_reg, st_next;
   stp_sample_t ul_reg, ul_next;
   logic        ulv_reg, ulv_next;
   logic        trst_reg, trst_next;
   logic        crst_reg, crst_next;
   logic        need_dl, need_ul, go;

   function automatic logic sends_dl(input stp_mode_e m);
      sends_dl = (m == MODE_DOWNLINK) || (m == MODE_ACOUSTIC);
   endfunction

   function automatic logic takes_ul(input stp_mode_e m);
      takes_ul = (m == MODE_UPLINK) || (m == MODE_ACOUSTIC);
   endfunction

   assign need_dl = sends_dl(mode_reg);
   assign need_ul = takes_ul(mode_reg);
   // clock only starts when every direction the mode uses can move a word
   // an aborted word must finish in the engine before a new one starts
   assign go = !wd.busy && (!need_dl || dl_valid) && (!need_ul || ul_ready);

   always_comb
   begin
      st_next    = st_reg;
      ul_next    = ul_reg;
      ulv_next   = 1'b0;
      trst_next  = 1'b0;
      crst_next  = rst_act;
      wd.start   = 1'b0;
      wd.tx_word = SAMPLE_ZERO;
      dl_ready   = 1'b0;
      case (st_reg)
         T_IDLE:
            st_next = T_IDLE;
         T_HOLD:
            if (release_ev)
            begin
               if (mode_reg != MODE_NORMAL)
               begin
                  trst_next = 1'b1;
                  st_next   = T_WAIT;
               end
               else
                  st_next = T_IDLE;
            end
         T_WAIT:
         begin
            // word count restarts here, no framing line exists
            case (mode_reg)
               MODE_UPLINK:
                  if (ul_block_start)
                     st_next = T_READY;
               MODE_DOWNLINK:
                  if (dl_frames_done)
                     st_next = T_READY;
               MODE_ACOUSTIC:
                  st_next = T_READY;
               default:
                  st_next = T_IDLE;
            endcase
         end
         T_READY:
            if (mode_reg == MODE_NORMAL)
               st_next = T_IDLE;
            else if (go)
            begin
               wd.start = 1'b1;
               if (need_dl)
               begin
                  wd.tx_word = dl_sample;
                  dl_ready   = 1'b1;
               end
               st_next = T_XFER;
            end
         T_XFER:
            if (wd.done)
            begin
               if (need_ul)
               begin
                  ul_next  = wd.rx_word;
                  ulv_next = 1'b1;
               end
               st_next = T_READY;
            end
         default:
            st_next = T_IDLE;
      endcase
      // a held reset pin forces T_HOLD, even mid word; a start, dl_ready or ul_valid raised this cycle still goes out
      if (rst_act)
         st_next = T_HOLD;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         st_reg   <= T_IDLE;
         ul_reg   <= SAMPLE_ZERO;
         ulv_reg  <= 1'b0;
         trst_reg <= 1'b0;
         crst_reg <= 1'b0;
      end
      else
      begin
         st_reg   <= st_next;
         ul_reg   <= ul_next;
         ulv_reg  <= ulv_next;
         trst_reg <= trst_next;
         crst_reg <= crst_next;
      end
   end

   // -------------------------------------------------------
   // bit engine
   // -------------------------------------------------------
   stp_bit_engine u_engine
   (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .wd        (wd.engine),
      .sdi_sync  (sdi_s),
      .sclk      (tst_sclk),
      .sdata_out (tst_sdata_out)
   );

   assign ul_sample      = ul_reg;
   assign ul_valid       = ulv_reg;
   assign path_mode      = mode_reg;
   assign transcoder_rst = trst_reg;
   assign conv_rst       = crst_reg;
   assign test_active    = (st_reg == T_READY) || (st_reg == T_XFER);

   // -------------------------------------------------------
   // checks
   // -------------------------------------------------------
   sequence s_release_test;
      release_ev && (mode_reg != MODE_NORMAL);
   endsequence

   sequence s_word_start;
      wd.start;
   endsequence

   trans_rst_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_release_test |=> transcoder_rst ##1 !transcoder_rst)
      else $error("no transcoder reset at release in test mode");
   conv_rst_held_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      rst_act [*2] |-> conv_rst && !test_active)
      else $error("converters not held while reset pin low");
   normal_no_clk_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (st_reg == T_IDLE) && !wd.busy |-> tst_sclk)
      else $error("link clock moves in normal operation");
   ul_wait_blk_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (st_reg == T_WAIT) && (mode_reg == MODE_UPLINK) && !ul_block_start
      && !rst_act |=> !wd.busy && (st_reg == T_WAIT))
      else $error("uplink clocked before block boundary");
   dl_take_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (s_word_start and need_dl) |-> dl_ready && dl_valid)
      else $error("downlink word sent without a sample");
   word_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_word_start |=> wd.busy [*8])
      else $error("word shorter than expected");
   ul_from_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ul_valid |-> $past(wd.done) && (ul_sample == $past(wd.rx_word)))
      else $error("uplink sample not from a finished word");
   demand_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_word_start |-> (st_reg == T_READY) && go)
      else $error("clock started without demand");
endmodule
`default_nettype wire

/* stp_sim_model.sv */
// model of the external test simulator on the serial side of the port
// assumes tst_sclk comes from the handset and idles high between words
`timescale 1ns/1ps
`default_nettype none
module stp_sim_model
(
   // link pins
   input  wire logic                 tst_sclk,
   input  wire logic                 tst_sdata_out,
   input  wire logic                 tst_rst_n,
   output logic                      tst_sdata_in,
   // test side
   input  wire stp_pkg::stp_sample_t tx_word,
   output stp_pkg::stp_sample_t      rx_word,
   output logic                      rx_strobe
);
   import stp_pkg::*;
   int          bit_cnt;
   stp_sample_t shift_reg;

   // --------------------------------------------------
   // serial exchange
   // --------------------------------------------------
   initial
   begin
      tst_sdata_in = 1'b1;
      rx_strobe    = 1'b0;
      rx_word      = SAMPLE_ZERO;
      shift_reg    = SAMPLE_ZERO;
      bit_cnt      = 0;
   end

   // word count restarts while the reset pin is low
   always @(negedge tst_rst_n)
      bit_cnt = 0;

   always @(negedge tst_sclk)
      tst_sdata_in <= tx_word[WORD_BITS-1-bit_cnt];

   always @(posedge tst_sclk)
   begin
      if (tst_rst_n === 1'b1)
      begin
         shift_reg = {shift_reg[WORD_BITS-2:0], tst_sdata_out};
         bit_cnt   = bit_cnt + 1;
         if (bit_cnt == WORD_BITS)
         begin
            bit_cnt   = 0;
            rx_word   = shift_reg;
            rx_strobe = 1'b1;
            #1 rx_strobe = 1'b0;
         end
         // hold time over: the line no longer shows the bit
         #1000 tst_sdata_in = ~tst_sdata_in;
      end
   end
endmodule
`default_nettype wire

/* tb_speech_test_serial_port.sv */
// self-checking bench for the speech test port
// assumes stp_port and stp_sim_model; link runs at 480+480 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_speech_test_serial_port;
   import stp_pkg::*;
   logic        sys_clk, sys_rst, tst_ctrl1, tst_ctrl2, tst_rst_n, tst_sdata_in;
   logic        tst_sclk, tst_sdata_out, cfg_use_msg, cfg_msg_valid, ul_block_start;
   logic        dl_frames_done, ul_valid, ul_ready, dl_valid, dl_ready, transcoder_rst;
   logic        conv_rst, test_active, rx_strobe, took_dl;
   stp_mode_e   cfg_msg_mode, path_mode;
   stp_sample_t ul_sample, dl_sample, tx_word, rx_word;
   stp_sample_t ul_q[$], link_q[$];
   int          fail_count, n_checks, n_falls, n_words, n_trst, seed, f0;
   realtime     t_fall;

   // --------------------------------------------------
   // instances
   // --------------------------------------------------
   stp_port dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .tst_ctrl1(tst_ctrl1),
      .tst_ctrl2(tst_ctrl2), .tst_rst_n(tst_rst_n), .tst_sdata_in(tst_sdata_in),
      .tst_sclk(tst_sclk), .tst_sdata_out(tst_sdata_out), .cfg_use_msg(cfg_use_msg),
      .cfg_msg_valid(cfg_msg_valid), .cfg_msg_mode(cfg_msg_mode),
      .ul_block_start(ul_block_start), .dl_frames_done(dl_frames_done),
      .ul_sample(ul_sample), .ul_valid(ul_valid), .ul_ready(ul_ready),
      .dl_sample(dl_sample), .dl_valid(dl_valid), .dl_ready(dl_ready),
      .path_mode(path_mode), .transcoder_rst(transcoder_rst), .conv_rst(conv_rst),
      .test_active(test_active));
   stp_sim_model sim_u (.tst_sclk(tst_sclk), .tst_sdata_out(tst_sdata_out),
      .tst_rst_n(tst_rst_n), .tst_sdata_in(tst_sdata_in), .tx_word(tx_word),
      .rx_word(rx_word), .rx_strobe(rx_strobe));

   initial
      sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;

   // --------------------------------------------------
   // tasks
   // --------------------------------------------------
   task automatic chk(input string name, input stp_sample_t exp, input stp_sample_t got);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic set_mode(input stp_mode_e m);
      {tst_ctrl1, tst_ctrl2} = m;
      cyc(5);
      chk("path_mode", stp_sample_t'(m), stp_sample_t'(path_mode));
   endtask

   // pulse and the settle time after release are shortened to keep the run short
   task automatic pulse_rst(input int exp_trst);
      int t0;
      t0 = n_trst;
      tst_rst_n = 1'b0;
      cyc(6);
      chk("conv_rst", 13'h0001, stp_sample_t'(conv_rst));
      tst_rst_n = 1'b1;
      cyc(6);
      chk("transcoder_rst count", stp_sample_t'(exp_trst), stp_sample_t'(n_trst - t0));
      chk("conv_rst released", SAMPLE_ZERO, stp_sample_t'(conv_rst));
   endtask

   task automatic wait_words(input int target);
      int k;
      k = 0;
      while (n_words < target && k < 20000)
      begin
         cyc(1);
         k++;
      end
      chk("word count", stp_sample_t'(target), stp_sample_t'(n_words));
   endtask

   task automatic end_sim;
      if (fail_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // --------------------------------------------------
   // monitors
   // --------------------------------------------------
   always @(posedge rx_strobe)
   begin
      n_words++;
      if (link_q.size() == 0)
      begin
         fail_count++;
         $display("unexpected link word expected none seen %h", rx_word);
      end
      else
         chk("link word", link_q.pop_front(), rx_word);
   end

   always @(negedge sys_clk)
      if (dl_ready === 1'b1)
         took_dl = 1'b1;

   always @(posedge sys_clk)
   begin
      if (transcoder_rst === 1'b1)
         n_trst++;
      #1;
      if (took_dl === 1'b1)
      begin
         dl_valid = 1'b0;
         took_dl  = 1'b0;
      end
      if (ul_valid === 1'b1)
      begin
         ul_ready = 1'b0;
         if (ul_q.size() == 0)
         begin
            fail_count++;
            $display("unexpected ul_sample expected none seen %h", ul_sample);
         end
         else
            chk("ul_sample", ul_q.pop_front(), ul_sample);
      end
   end

   always @(negedge tst_sclk)
   begin
      if (n_falls == 1)
         chk("bit period", 13'h0001, stp_sample_t'($realtime - t_fall == 9600.0));
      n_falls++;
      t_fall = $realtime;
   end

   initial
   begin
      #700000;
      fail_count++;
      end_sim();
   end

   // --------------------------------------------------
   // main sequence
   // --------------------------------------------------
   initial
   begin
      seed = 79757;
      {sys_rst, tst_rst_n, tst_ctrl1, tst_ctrl2, cfg_use_msg, cfg_msg_valid} = 6'h20;
      {ul_block_start, dl_frames_done, ul_ready, dl_valid, took_dl} = 5'h00;
      {dl_sample, tx_word} = {SAMPLE_ZERO, SAMPLE_ZERO};
      cfg_msg_mode = MODE_NORMAL;
      {fail_count, n_checks, n_falls, n_words, n_trst} = '0;
      t_fall = 0.0;
      cyc(8);
      sys_rst = 1'b0;
      cyc(4);
      // message stored but ignored while the lines rule
      cfg_msg_mode  = MODE_ACOUSTIC;
      cfg_msg_valid = 1'b1;
      cyc(1);
      cfg_msg_valid = 1'b0;
      for (int m = 0; m < 4; m++)
         set_mode(stp_mode_e'(m));
      set_mode(MODE_NORMAL);
      f0 = n_falls;
      pulse_rst(0);
      cyc(2000);
      chk("normal falls", SAMPLE_ZERO, stp_sample_t'(n_falls - f0));
      chk("normal test_active", SAMPLE_ZERO, stp_sample_t'(test_active));
      // uplink with the most negative sample
      set_mode(MODE_UPLINK);
      tx_word = 13'h1000;
      ul_q.push_back(13'h1000);
      link_q.push_back(SAMPLE_ZERO);
      ul_ready = 1'b1;
      pulse_rst(1);
      cyc(200);
      chk("falls before block", SAMPLE_ZERO, stp_sample_t'(n_falls - f0));
      ul_block_start = 1'b1;
      cyc(1);
      ul_block_start = 1'b0;
      wait_words(1);
      cyc(600);
      // downlink then idle
      set_mode(MODE_DOWNLINK);
      // offer the sample only after release: the port still sits ready
      // and would clock it out ahead of the reset pulse
      pulse_rst(1);
      dl_sample = stp_sample_t'($random(seed));
      dl_valid  = 1'b1;
      link_q.push_back(dl_sample);
      f0 = n_falls;
      cyc(200);
      chk("falls before frames", SAMPLE_ZERO, stp_sample_t'(n_falls - f0));
      chk("wait test_active", SAMPLE_ZERO, stp_sample_t'(test_active));
      dl_frames_done = 1'b1;
      cyc(1);
      dl_frames_done = 1'b0;
      wait_words(2);
      f0 = n_falls;
      cyc(2000);
      chk("idle falls", SAMPLE_ZERO, stp_sample_t'(n_falls - f0));
      chk("idle sclk", 13'h0001, stp_sample_t'(tst_sclk));
      // acoustic taken from the message, both directions
      cfg_use_msg   = 1'b1;
      cfg_msg_valid = 1'b1;
      cyc(1);
      cfg_msg_valid = 1'b0;
      {tst_ctrl1, tst_ctrl2} = 2'b00;
      cyc(5);
      chk("msg path_mode", stp_sample_t'(MODE_ACOUSTIC), stp_sample_t'(path_mode));
      tx_word   = stp_sample_t'($random(seed));
      dl_sample = stp_sample_t'($random(seed));
      ul_q.push_back(tx_word);
      link_q.push_back(dl_sample);
      pulse_rst(1);
      {dl_valid, ul_ready} = 2'b11;
      wait_words(3);
      chk("xfer test_active", 13'h0001, stp_sample_t'(test_active));
      cyc(600);
      chk("ul left", SAMPLE_ZERO, stp_sample_t'(ul_q.size()));
      chk("link left", SAMPLE_ZERO, stp_sample_t'(link_q.size()));
      end_sim();
   end
endmodule
`default_nettype wire
